// ### pdp_ext_equip.sv
// external equipment model wired to the connector pins
`timescale 1ns/100ps
`default_nettype none
module pdp_ext_equip (
	input  wire logic [15:0] pin_o,
	input  wire logic [15:0] pin_oe_n,
	input  wire logic [15:0] ext_lvl,
	input  wire logic        clash,
	output logic      [15:0] pin_i
);
	// released pins show the equipment level; clash fights driven pins too
	logic [15:0] ext_wins;
	assign ext_wins = pin_oe_n | {16{clash}};
	assign pin_i    = (ext_wins & ext_lvl) | (~ext_wins & pin_o);
endmodule : pdp_ext_equip
`default_nettype wire

// ### pdp_pair_cell.sv
// module: output stage and read-back of one bit pair
`timescale 1ns/100ps
`default_nettype none
module pdp_pair_cell
	import pdp_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire pdp_cfg_type cfg_even,
	input  wire pdp_cfg_type cfg_odd,
	input  wire logic [1:0]  wdata,
	input  wire logic        fault,
	input  wire logic        pf,
	input  wire logic [1:0]  pin_i,
	output logic [1:0]       pin_o,
	output logic [1:0]       pin_oe_n,
	output logic [1:0]       rd
);
	logic [1:0] o_d;
	logic [1:0] o_q;
	logic [1:0] oe_n_d;
	logic [1:0] oe_n_q;
	logic       iso;
	logic       lv_even;

	function automatic logic drive_level(input pdp_cfg_type c, input logic d,
		input logic f, input logic p);
		logic lv;
		lv = 1'b1;
		unique case (c.func)
			general_bidir_function:  lv = d;
			general_output_function: lv = d;
			general_input_function:  lv = 1'b1;
			fault_follower_output:   lv = f;
			power_loss_output:       lv = p;
			fault_gated_output:      lv = d & ~f;
			default:                 lv = 1'b1;
		endcase
		return (c.pol == active_high_polarity) ? lv : ~lv;
	endfunction : drive_level

	function automatic logic sense(input pdp_cfg_type c, input logic d, input logic pin);
		logic s;
		s = d;
		if (c.func == general_input_function || c.func == general_bidir_function) begin
			s = (c.pol == active_high_polarity) ? pin : ~pin;
		end
		return s;
	endfunction : sense

	always_comb begin
		iso     = cfg_even.refsel == pair_isolated_reference;
		lv_even = drive_level(cfg_even, wdata[0], fault, pf);
		if (iso) begin
			// isolator plus and minus are driven as a complementary pair
			o_d    = {~lv_even, lv_even};
			oe_n_d = 2'b00;
			rd     = {1'b0, wdata[0]};
		end else begin
			// open collector: only a low level is driven
			o_d       = 2'b00;
			oe_n_d[0] = (cfg_even.func == general_input_function) | lv_even;
			oe_n_d[1] = (cfg_odd.func == general_input_function)
				| drive_level(cfg_odd, wdata[1], fault, pf);
			rd[0]     = sense(cfg_even, wdata[0], pin_i[0]);
			rd[1]     = sense(cfg_odd, wdata[1], pin_i[1]);
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			o_q    <= 2'b00;
			oe_n_q <= 2'b11;
		end else begin
			o_q    <= o_d;
			oe_n_q <= oe_n_d;
		end
	end

	assign pin_o    = o_q;
	assign pin_oe_n = oe_n_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	sequence gated_fault_s;
		(!srst && iso && cfg_even.func == fault_gated_output && fault) [*2];
	endsequence

	gated_off_a: assert property (
		gated_fault_s |-> pin_o[0] == (cfg_even.pol == active_low_polarity))
	else $error("gated pair output not false under fault");

	follower_a: assert property (
		!srst && iso && cfg_even.func == fault_follower_output
		|=> pin_o[0] == $past(fault ^ (cfg_even.pol == active_low_polarity)))
	else $error("fault follower pair does not track fault input");

	polarity_a: assert property (
		!srst && iso && cfg_even.func == general_output_function
		|=> pin_o[0] == $past(wdata[0] ^ (cfg_even.pol == active_low_polarity))
			&& pin_o[1] == ~pin_o[0])
	else $error("isolated pair level wrong for even bit and polarity");

	iso_read_a: assert property (
		iso && $stable(wdata[0]) && $stable(cfg_even) |-> $stable(rd) && !rd[1])
	else $error("isolated pair read depends on pins or odd bit set");

	iso_drive_a: assert property (
		!srst && iso |=> pin_oe_n == 2'b00 && pin_o[1] == ~pin_o[0])
	else $error("isolated pair not driven as one output");
endmodule : pdp_pair_cell
`default_nettype wire

// ### pdp_pkg.sv
// package: constants and types of the paired isolated digital port
`default_nettype none
package pdp_pkg;
	localparam int          NBITS          = 16;
	localparam int          NPAIRS         = 8;
	localparam logic [11:0] ADDR_DATA      = 12'h000;
	localparam logic [11:0] ADDR_STAT      = 12'h004;
	localparam logic [5:0]  ADDR_CFG_BLK   = 6'h01;
	localparam int          STAT_FAULT_POS = 0;
	localparam int          STAT_PF_POS    = 1;
	localparam logic [15:0] DATA_RST       = 16'h0000;
	typedef enum logic [3:0] {
		general_bidir_function,
		general_output_function,
		general_input_function,
		fault_follower_output,
		power_loss_output,
		fault_gated_output
	} pdp_func_type;
	localparam logic [3:0] FUNC_COUNT = 4'h6;
	typedef enum logic {
		chassis_single_ended_reference,
		pair_isolated_reference
	} pdp_ref_type;
	typedef enum logic {
		active_low_polarity,
		active_high_polarity
	} pdp_pol_type;
	typedef struct packed {
		pdp_func_type func;
		pdp_pol_type  pol;
		pdp_ref_type  refsel;
	} pdp_cfg_type;
	localparam int          CFG_W       = $bits(pdp_cfg_type);
	localparam pdp_cfg_type CFG_DEFAULT = '{
		func:   general_bidir_function,
		pol:    active_low_polarity,
		refsel: chassis_single_ended_reference
	};
endpackage : pdp_pkg
`default_nettype wire

// ### pdp_port_top.sv
// module: apb slave, configuration store and port word of the digital port
`timescale 1ns/100ps
`default_nettype none
module pdp_port_top
	import pdp_pkg::*;
(
	input  wire logic        SYS_CLK,
	input  wire logic        SRST,
	input  wire logic        PWR_ON_RST,
	input  wire logic        EXT_FAULT,
	input  wire logic        PF_SAVED,
	input  wire logic        RUN_START,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic [15:0] PIN_I,
	output logic      [15:0] PIN_O,
	output logic      [15:0] PIN_OE_N
);
	pdp_cfg_type               cfg_q [NBITS];
	pdp_cfg_type               cfg_d [NBITS];
	logic [15:0]               data_q;
	logic [15:0]               data_d;
	logic                      pf_q;
	logic                      pf_d;
	logic [31:0]               rdata_q;
	logic [31:0]               rdata_d;
	logic [15:0]               port_rd;
	logic                      setup;
	logic                      access;
	logic                      wr;
	logic                      hit_data;
	logic                      hit_stat;
	logic                      hit_cfg;
	logic                      cfg_ok;
	logic [3:0]                idx;
	logic [3:0]                pidx;
	pdp_cfg_type               new_cfg;
	logic [NBITS*CFG_W-1:0]    cfg_flat;
	logic [15:0]               iso_odd_mask;

	function automatic logic iso_func_ok(input pdp_func_type f);
		return f == general_output_function || f == fault_follower_output
			|| f == power_loss_output || f == fault_gated_output;
	endfunction : iso_func_ok

	always_comb begin
		setup    = PSEL & ~PENABLE;
		access   = PSEL & PENABLE;
		wr       = access & PWRITE;
		idx      = PADDR[5:2];
		pidx     = {idx[3:1], ~idx[0]};
		hit_data = PADDR == ADDR_DATA;
		hit_stat = PADDR == ADDR_STAT;
		hit_cfg  = PADDR[11:6] == ADDR_CFG_BLK && PADDR[1:0] == 2'b00;
		new_cfg  = pdp_cfg_type'(PWDATA[CFG_W-1:0]);
		cfg_ok   = PWDATA[CFG_W-1:2] < FUNC_COUNT
			&& (new_cfg.refsel == chassis_single_ended_reference
			|| iso_func_ok(new_cfg.func));
	end

	// zero wait states; bad offsets and illegal pair functions answer with an error
	assign PREADY  = 1'b1;
	assign PSLVERR = access & (~(hit_data | hit_stat | hit_cfg)
		| (PWRITE & hit_cfg & ~cfg_ok));
	assign PRDATA  = rdata_q;

	always_comb begin
		for (int i = 0; i < NBITS; i++) begin
			cfg_d[i] = cfg_q[i];
		end
		if (PWR_ON_RST) begin
			for (int i = 0; i < NBITS; i++) begin
				cfg_d[i] = CFG_DEFAULT;
			end
		end else if (wr && hit_cfg && cfg_ok) begin
			cfg_d[idx] = new_cfg;
			if (new_cfg.refsel == pair_isolated_reference) begin
				cfg_d[pidx] = new_cfg;
			end else if (cfg_q[idx].refsel == pair_isolated_reference) begin
				cfg_d[pidx] = CFG_DEFAULT;
			end
		end
	end

	// only power-on resets the store, so an instrument reset keeps it
	always_ff @(posedge SYS_CLK) begin
		cfg_q <= cfg_d;
	end

	always_comb begin
		data_d = data_q;
		if (wr && hit_data) begin
			data_d = PWDATA[15:0];
		end
		pf_d = PF_SAVED | (pf_q & ~RUN_START & ~PWR_ON_RST);
	end

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			data_q <= DATA_RST;
		end else begin
			data_q <= data_d;
		end
		pf_q <= pf_d;
	end

	// read data is captured in the setup cycle so it comes from a flip-flop
	always_comb begin
		rdata_d = rdata_q;
		if (setup) begin
			rdata_d = 32'h0000_0000;
			if (hit_data) begin
				rdata_d[15:0] = port_rd;
			end else if (hit_stat) begin
				rdata_d[STAT_FAULT_POS] = EXT_FAULT;
				rdata_d[STAT_PF_POS]    = pf_q;
			end else if (hit_cfg) begin
				rdata_d[CFG_W-1:0] = cfg_q[idx];
			end
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	for (genvar p = 0; p < NPAIRS; p++) begin : g_pair
		pdp_pair_cell u_cell (
			.clk      (SYS_CLK),
			.srst     (SRST),
			.cfg_even (cfg_q[2*p]),
			.cfg_odd  (cfg_q[2*p+1]),
			.wdata    (data_q[2*p +: 2]),
			.fault    (EXT_FAULT),
			.pf       (pf_q),
			.pin_i    (PIN_I[2*p +: 2]),
			.pin_o    (PIN_O[2*p +: 2]),
			.pin_oe_n (PIN_OE_N[2*p +: 2]),
			.rd       (port_rd[2*p +: 2])
		);
	end

	always_comb begin
		for (int i = 0; i < NBITS; i++) begin
			cfg_flat[i*CFG_W +: CFG_W] = cfg_q[i];
		end
	end

	// odd read bits that an isolated pair must hold at zero
	always_comb begin
		iso_odd_mask = 16'h0000;
		for (int p = 0; p < NPAIRS; p++) begin
			iso_odd_mask[2*p+1] = cfg_q[2*p].refsel == pair_isolated_reference;
		end
	end

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (SRST);

	sequence pair_write_s;
		wr && hit_cfg && cfg_ok && !PWR_ON_RST;
	endsequence

	sequence run_clear_s;
		RUN_START && !PF_SAVED ##1 !pf_q;
	endsequence

	data_write_a: assert property (
		wr && hit_data |=> data_q == $past(PWDATA[15:0]))
	else $error("port word not taken in one edge");

	pair_join_a: assert property (
		pair_write_s and new_cfg.refsel == pair_isolated_reference
		|=> cfg_q[$past(idx)] == $past(new_cfg)
			&& cfg_q[$past(pidx)] == $past(new_cfg))
	else $error("isolated setting did not cover both bits");

	iso_reject_a: assert property (
		access && PWRITE && hit_cfg && !PWR_ON_RST
		&& new_cfg.refsel == pair_isolated_reference && !iso_func_ok(new_cfg.func)
		|-> PSLVERR ##1 cfg_flat == $past(cfg_flat))
	else $error("illegal pair function accepted");

	split_default_a: assert property (
		pair_write_s and new_cfg.refsel == chassis_single_ended_reference
		and cfg_q[idx].refsel == pair_isolated_reference
		|=> cfg_q[$past(pidx)] == CFG_DEFAULT)
	else $error("partner not defaulted on leaving isolated mode");

	pf_set_a: assert property (
		PF_SAVED |=> pf_q [*1] ##0 (PF_SAVED || RUN_START || PWR_ON_RST || pf_q))
	else $error("power loss flag not set");

	pf_clear_a: assert property (
		RUN_START && !PF_SAVED |-> run_clear_s)
	else $error("power loss flag not cleared by run start");

	reset_hold_a: assert property (
		disable iff (PWR_ON_RST)
		SRST |=> data_q == DATA_RST && cfg_flat == $past(cfg_flat))
	else $error("reset cleared the store or kept the port word");

	stat_read_a: assert property (
		!SRST && setup && hit_stat
		|=> PRDATA == {30'h0, $past(pf_q), $past(EXT_FAULT)})
	else $error("status read lost fault or power loss flag");

	odd_read_a: assert property (
		!SRST && setup && hit_data
		|=> (PRDATA[15:0] & $past(iso_odd_mask)) == 16'h0000 && PRDATA[31:16] == 16'h0000)
	else $error("isolated pair read shows an odd bit");

	por_default_a: assert property (
		PWR_ON_RST |=> cfg_flat == {NBITS{CFG_DEFAULT}})
	else $error("power-on did not load the default configuration");
endmodule : pdp_port_top
`default_nettype wire

// ### pdp_port_top_tb.sv
// self-checking testbench of the paired isolated digital port
`timescale 1ns/100ps
`default_nettype none
module pdp_port_top_tb;
	logic        clk, srst, por, fault, pf_saved, run_start, clash;
	logic        psel, pen, pwr, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [15:0] pin_i, pin_o, pin_oe_n, ext, w;
	logic [33:0] ex;
	logic [33:0] q[$];
	int          failures, checks_done;
	localparam logic [7:0] TC[6] = '{8'h07, 8'h05, 8'h0f, 8'h0f, 8'h17, 8'h17};
	localparam logic [5:0] TF    = 6'b010100;
	localparam logic [5:0] TE    = 6'b100101;

	pdp_port_top DUT (
		.SYS_CLK    (clk),
		.SRST       (srst),
		.PWR_ON_RST (por),
		.EXT_FAULT  (fault),
		.PF_SAVED   (pf_saved),
		.RUN_START  (run_start),
		.PSEL       (psel),
		.PENABLE    (pen),
		.PWRITE     (pwr),
		.PADDR      (paddr),
		.PWDATA     (pwdata),
		.PRDATA     (prdata),
		.PREADY     (pready),
		.PSLVERR    (pslverr),
		.PIN_I      (pin_i),
		.PIN_O      (pin_o),
		.PIN_OE_N   (pin_oe_n)
	);
	pdp_ext_equip EQ (
		.pin_o    (pin_o),
		.pin_oe_n (pin_oe_n),
		.ext_lvl  (ext),
		.clash    (clash),
		.pin_i    (pin_i)
	);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	function automatic logic [11:0] cfa(input int n);
		return 12'h040 + 12'(4 * n);
	endfunction : cfa

	// note expected answer, then hold the request until pready
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
			input logic err, input logic [31:0] x);
		q.push_back({~wr, err, x});
		@(posedge clk);
		psel   <= 1'b1;
		pen    <= 1'b0;
		pwr    <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		psel <= 1'b0;
		pen  <= 1'b0;
	endtask : apb

	// pins follow one edge after the register they come from
	task automatic chk(input logic [15:0] e, input logic [15:0] eo, input logic [15:0] m);
		repeat (2) @(posedge clk);
		@(negedge clk);
		checks_done++;
		if ((pin_o & m) !== e) begin
			failures++;
			$display("wrong value PIN_O exp %h got %h", e, pin_o & m);
		end
		checks_done++;
		if ((pin_oe_n & m) !== eo) begin
			failures++;
			$display("wrong value PIN_OE_N exp %h got %h", eo, pin_oe_n & m);
		end
	endtask : chk

	always @(posedge clk) begin
		if (psel && pen && pready) begin
			ex = q.pop_front();
			checks_done++;
			if (pslverr !== ex[32] || (ex[33] && prdata !== ex[31:0])) begin
				failures++;
				$display("wrong value apb %h exp %h got %b %h", paddr, ex[32:0], pslverr, prdata);
			end
		end
	end

	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : final_report

	initial begin
		#300000;
		failures++;
		final_report();
	end

	initial begin
		{fault, pf_saved, run_start, psel, pen, pwr, clash} = '0;
		paddr  = '0;
		pwdata = '0;
		ext    = '0;
		srst   = 1'b1;
		por    = 1'b1;
		void'($urandom(32'hcf1c));
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		por  <= 1'b0;
		chk(16'h0000, 16'hffff, 16'hffff);
		$display("test reset done");
		for (int p = 0; p < 8; p++) begin
			apb(1'b1, cfa(2 * p + p % 2), 32'h07, 1'b0, '0);
			apb(1'b0, cfa(2 * p + 1 - p % 2), '0, 1'b0, 32'h07);
		end
		$display("test pair setup done");
		for (int i = 0; i < 10; i++) begin
			w = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : 16'($urandom);
			ext   <= 16'($urandom);
			clash <= i[0];
			apb(1'b1, 12'h000, {16'h0, w}, 1'b0, '0);
			chk((w & 16'h5555) | ((~w & 16'h5555) << 1), 16'h0000, 16'hffff);
			apb(1'b0, 12'h000, '0, 1'b0, {16'h0, w & 16'h5555});
		end
		clash <= 1'b0;
		$display("test port word done");
		apb(1'b1, 12'h000, 32'h1, 1'b0, '0);
		for (int i = 0; i < 6; i++) begin
			fault <= TF[i];
			apb(1'b1, 12'h040, {24'h0, TC[i]}, 1'b0, '0);
			chk({15'h0, TE[i]}, 16'h0000, 16'h0001);
		end
		fault <= 1'b0;
		$display("test pair functions done");
		apb(1'b1, 12'h040, 32'h13, 1'b0, '0);
		chk(16'h0000, 16'h0000, 16'h0001);
		@(posedge clk) pf_saved <= 1'b1;
		@(posedge clk) pf_saved <= 1'b0;
		chk(16'h0001, 16'h0000, 16'h0001);
		apb(1'b0, 12'h004, '0, 1'b0, 32'h2);
		@(posedge clk) run_start <= 1'b1;
		@(posedge clk) run_start <= 1'b0;
		chk(16'h0000, 16'h0000, 16'h0001);
		$display("test power loss done");
		apb(1'b1, 12'h040, 32'h0b, 1'b1, '0);
		apb(1'b1, 12'h048, 32'h18, 1'b1, '0);
		apb(1'b0, 12'h040, '0, 1'b0, 32'h13);
		apb(1'b0, 12'h800, '0, 1'b1, '0);
		$display("test refusals done");
		@(posedge clk) srst <= 1'b1;
		@(posedge clk) srst <= 1'b0;
		apb(1'b0, 12'h044, '0, 1'b0, 32'h13);
		apb(1'b0, 12'h000, '0, 1'b0, '0);
		apb(1'b1, 12'h040, '0, 1'b0, '0);
		apb(1'b0, 12'h044, '0, 1'b0, '0);
		// split pair: bit 0 pulls low, bit 1 released shows the equipment level
		apb(1'b1, 12'h000, 32'h1, 1'b0, '0);
		chk(16'h0000, 16'h0002, 16'h0003);
		apb(1'b0, 12'h000, '0, 1'b0, {30'h0, ~ext[1], 1'b1});
		$display("test reset keep and regroup done");
		final_report();
	end
endmodule : pdp_port_top_tb
`default_nettype wire
